// file: core/smds_params.svh
// Purpose: Constants for the speed mode data selector (offsets, fields, resets, timing)
// Assumes: Included by its bare name; definitions only
// Notes:   Register offsets are word indices on the plain register port
`ifndef SMDS_PARAMS_SVH
`define SMDS_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SMDS_ADDR_W 8
`define SMDS_REG_SPEED_BASE 8'h00
`define SMDS_REG_ACCEL_BASE 8'h08
`define SMDS_REG_DECEL_BASE 8'h10
`define SMDS_REG_TORQUE_BASE 8'h18
`define SMDS_REG_SYS_PEND 8'h20
`define SMDS_REG_SYS_ACTIVE 8'h21
`define SMDS_REG_APP_CTRL 8'h22
`define SMDS_REG_ZERO_BAND 8'h23
`define SMDS_REG_ATTAIN_BAND 8'h24
`define SMDS_REG_MOVE_MIN 8'h25
`define SMDS_REG_GAIN 8'h26
`define SMDS_REG_CLAMP 8'h27
`define SMDS_REG_OFFSET 8'h28
`define SMDS_REG_GEAR_A 8'h29
`define SMDS_REG_GEAR_B 8'h2A
`define SMDS_REG_STATUS 8'h2B
`define SMDS_REG_CMD_SPEED 8'h2C
`define SMDS_REG_AUTO_OFS 8'h2D

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SMDS_SYS_ANALOG_EN 0
`define SMDS_SYS_SERVO_LOCK 1
`define SMDS_SYS_SENSE_CCW 2
`define SMDS_APP_SON_INV 0
`define SMDS_APP_BRAKE_INV 1
`define SMDS_APP_ALARM_EN 2
`define SMDS_APP_AUTO_OFS 3

// ----------------------------------------------------------------
// Reset values, and millivolts per volt for analog scaling
// ----------------------------------------------------------------
`define SMDS_SYS_PEND_RST 3'h1
`define SMDS_GAIN_RST 16'h0226
`define SMDS_GEAR_RST 16'h0001
`define SMDS_MV_PER_V 32'h000003E8

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SMDS_CLK_PERIOD_NS 100
`define SMDS_MS_NS 1000000
`define SMDS_CYC_PER_MS (`SMDS_MS_NS / `SMDS_CLK_PERIOD_NS)

`endif

// file: core/smds_pkg.sv
// Purpose: Types for the speed mode data selector
// Assumes: smds_params.svh supplies reset constants
// Notes:   Whole block state is one packed struct
`include "smds_params.svh"

package smds_pkg;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SMDS_STOP, SMDS_CW, SMDS_CCW} smds_run_e;

  typedef struct packed {
    logic [2:0] sel_s1;
    logic [2:0] sel_s2;
    logic [1:0] dir_s1;
    logic [1:0] dir_s2;
    logic [7:0][15:0] spd;
    logic [7:0][15:0] acc;
    logic [7:0][15:0] dec;
    logic [7:0][15:0] trq;
    logic [2:0] sys_pend;
    logic [2:0] sys_act;
    logic [3:0] app_ctrl;
    logic [15:0] zero_band;
    logic [15:0] attain_band;
    logic [15:0] move_min;
    logic [15:0] gain;
    logic [15:0] clamp;
    logic [15:0] offset;
    logic [15:0] gear_a;
    logic [15:0] gear_b;
    smds_run_e run;
    logic [15:0] move_ms;
    logic [13:0] ms_pre;
    logic [17:0] gear_acc;
    logic [15:0] cmd_speed;
    logic [15:0] cmd_acc;
    logic [15:0] cmd_dec;
    logic [15:0] cmd_trq;
    logic [2:0] sel_idx;
    logic excite;
    logic brake_rel;
    logic zero_out;
    logic attain_out;
    logic move_out;
    logic enc_out;
    logic [3:0] alarm_out;
    logic [15:0] rdata;
  } smds_state_s;

  // Cold reset image of the whole state
  function automatic smds_state_s smds_reset_state();
    smds_state_s r;
    r = '0;
    r.sys_pend = `SMDS_SYS_PEND_RST;
    r.sys_act = `SMDS_SYS_PEND_RST;
    r.gain = `SMDS_GAIN_RST;
    r.gear_a = `SMDS_GEAR_RST;
    r.gear_b = `SMDS_GEAR_RST;
    return r;
  endfunction

endpackage

// file: core/smds_selector.sv
// Purpose: Speed control mode entry selection, ramp and torque pick, status outputs
// Assumes: All inputs synchronous to i_clock; analog values arrive already digitised
// Notes:   i_por is a full power-on reset; i_rst is a power cycle that keeps pending system settings
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none

`include "smds_params.svh"

// Notes on behaviour
// - Motor runs continuously while exactly one direction input stays asserted.
// - Eight entries, 0 to 7, each with speed and ramp time.
// - Analog mode: entry 0 speed pot, entry 1 analog input, ramp pot.
// - Digital mode: all eight entries use stored speed and ramp values.
// - Pot-derived ramp time drives acceleration and deceleration alike.
// - Torque limit always comes from the same entry index as speed.
// - Select bits form binary index, bit 2 most significant, ON is one.
// - A setting inverts the servo-on input polarity.
// - A setting inverts the brake input polarity.
// - Zero-speed and speed-attained outputs each use their own band.
// - Motion output stays on at least the configured minimum time.
// - A setting enables alarm codes onto the outputs.
// - Analog speed: subtract offset voltage, then scale by speed per volt.
// - Scaled analog speed below clamp speed is forced to zero.
// - Encoder output pulses scaled by gear B over gear A.
// - Automatic analog offset capture can be enabled instead of a parameter.
// - System settings take effect only after the next power cycle.
// - Free mode: excitation and brake release follow motion.
// - Servo lock: excitation and brake release follow servo-on.
module smds_selector
  import smds_pkg::*;
#(
  parameter int P_CYC_PER_MS = `SMDS_CYC_PER_MS
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_por,
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  input wire logic i_entry_select_bit0,
  input wire logic i_entry_select_bit1,
  input wire logic i_entry_select_bit2,
  input wire logic i_run_clockwise_input,
  input wire logic i_run_counterclockwise_input,
  input wire logic i_servo_on,
  input wire logic i_brake,
  input wire logic [15:0] i_internal_speed_pot,
  input wire logic [15:0] i_internal_ramp_pot,
  input wire logic [15:0] i_analog_mv,
  input wire logic [15:0] i_motor_speed,
  input wire logic [3:0] i_alarm_code,
  input wire logic i_encoder_pulse,
  output logic [15:0] o_speed_cmd,
  output logic [15:0] o_accel_time,
  output logic [15:0] o_decel_time,
  output logic [15:0] o_torque_limit,
  output logic [2:0] o_entry_index,
  output logic o_run_cw,
  output logic o_run_ccw,
  output logic o_excite,
  output logic o_brake_release,
  output logic o_zero_speed_output,
  output logic o_speed_attained_output,
  output logic o_motion_output,
  output logic [3:0] o_alarm_code,
  output logic o_encoder_pulse_out
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Magnitude of a difference, used for the speed-attained band
  function automatic logic [15:0] smds_absdiff(input logic [15:0] a, input logic [15:0] b);
    logic [15:0] r;
    r = (a >= b) ? (a - b) : (b - a);
    return r;
  endfunction

  // Magnitude of a signed speed
  function automatic logic [15:0] smds_mag(input logic [15:0] v);
    logic [15:0] r;
    r = v[15] ? (16'h0000 - v) : v;
    return r;
  endfunction

  smds_state_s s_q;
  smds_state_s s_d;

  localparam logic [13:0] MS_LAST = 14'(P_CYC_PER_MS - 1);

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic [2:0] sel;
    logic analog_en;
    logic [16:0] ana_diff;
    logic [31:0] ana_prod;
    logic [31:0] ana_quot;
    logic [15:0] ana_spd;
    logic cw;
    logic run_counterclockwise_input;
    logic brake_ok;
    logic son;
    logic moving;
    logic [15:0] fb_mag;
    logic [18:0] gsum;
    logic [7:0] a;
    sel = '0;
    analog_en = 1'b0;
    ana_diff = '0;
    ana_prod = '0;
    ana_quot = '0;
    ana_spd = '0;
    cw = 1'b0;
    run_counterclockwise_input = 1'b0;
    brake_ok = 1'b0;
    son = 1'b0;
    moving = 1'b0;
    fb_mag = '0;
    gsum = '0;
    a = i_addr;

    s_d = s_q;

    // Two flops per select and direction input; only the second stage is decoded
    s_d.sel_s1 = {i_entry_select_bit2, i_entry_select_bit1, i_entry_select_bit0};
    s_d.sel_s2 = s_q.sel_s1;
    s_d.dir_s1 = {i_run_counterclockwise_input, i_run_clockwise_input};
    s_d.dir_s2 = s_q.dir_s1;

    sel = s_q.sel_s2;
    analog_en = s_q.sys_act[`SMDS_SYS_ANALOG_EN];

    // Analog speed: offset removed before scaling, negative result gives zero
    ana_diff = 17'($signed({i_analog_mv[15], i_analog_mv}) - $signed({s_q.offset[15], s_q.offset}));
    if (!ana_diff[16]) begin
      ana_prod = 32'(ana_diff[15:0]) * 32'(s_q.gain);
      ana_quot = ana_prod / `SMDS_MV_PER_V;
      ana_spd = (ana_quot[31:16] != 16'h0000) ? 16'hFFFF : ana_quot[15:0];
    end
    // Clamp small commands to zero so a noisy zero volts cannot creep
    if (ana_spd < s_q.clamp) begin
      ana_spd = 16'h0000;
    end

    // Entry pick; torque limit shares the index with speed
    s_d.sel_idx = sel;
    s_d.cmd_speed = s_q.spd[sel];
    s_d.cmd_acc = s_q.acc[sel];
    s_d.cmd_dec = s_q.dec[sel];
    s_d.cmd_trq = s_q.trq[sel];
    if (analog_en && sel == 3'h0) begin
      s_d.cmd_speed = i_internal_speed_pot;
      s_d.cmd_acc = i_internal_ramp_pot;
      s_d.cmd_dec = i_internal_ramp_pot;
    end else if (analog_en && sel == 3'h1) begin
      s_d.cmd_speed = ana_spd;
      s_d.cmd_acc = i_internal_ramp_pot;
      s_d.cmd_dec = i_internal_ramp_pot;
    end

    // Direction with rotation sense; both inputs at once means stop
    cw = s_q.dir_s2[0];
    run_counterclockwise_input = s_q.dir_s2[1];
    if (s_q.sys_act[`SMDS_SYS_SENSE_CCW]) begin
      cw = s_q.dir_s2[1];
      run_counterclockwise_input = s_q.dir_s2[0];
    end
    brake_ok = i_brake ^ s_q.app_ctrl[`SMDS_APP_BRAKE_INV];
    son = i_servo_on ^ s_q.app_ctrl[`SMDS_APP_SON_INV];
    if (brake_ok && cw && !run_counterclockwise_input) begin
      s_d.run = SMDS_CW;
    end else if (brake_ok && run_counterclockwise_input && !cw) begin
      s_d.run = SMDS_CCW;
    end else begin
      s_d.run = SMDS_STOP;
    end

    // Excitation and brake release move together in both modes
    moving = (s_q.run != SMDS_STOP);
    if (s_q.sys_act[`SMDS_SYS_SERVO_LOCK]) begin
      s_d.excite = son;
    end else begin
      s_d.excite = moving;
    end
    s_d.brake_rel = s_d.excite;

    // Speed bands against feedback magnitude
    fb_mag = smds_mag(i_motor_speed);
    s_d.zero_out = (fb_mag <= s_q.zero_band);
    s_d.attain_out = moving && (smds_absdiff(fb_mag, s_q.cmd_speed) <= s_q.attain_band);

    // Millisecond tick; minimum on-time resolution is one tick
    s_d.ms_pre = (s_q.ms_pre == MS_LAST) ? 14'h0000 : (s_q.ms_pre + 14'h0001);
    if (moving && !s_q.move_out) begin
      s_d.move_ms = s_q.move_min;
    end else if (s_q.ms_pre == MS_LAST && s_q.move_ms != 16'h0000) begin
      s_d.move_ms = s_q.move_ms - 16'h0001;
    end
    s_d.move_out = moving || (s_d.move_ms != 16'h0000);

    // Alarm code gate
    s_d.alarm_out = s_q.app_ctrl[`SMDS_APP_ALARM_EN] ? i_alarm_code : 4'h0;

    // Gear accumulator; at most one output pulse per clock, so B above A needs sparse input
    gsum = 19'(s_q.gear_acc) + (i_encoder_pulse ? 19'(s_q.gear_b) : 19'h00000);
    s_d.enc_out = 1'b0;
    if (s_q.gear_a != 16'h0000 && gsum >= 19'(s_q.gear_a)) begin
      gsum = gsum - 19'(s_q.gear_a);
      s_d.enc_out = 1'b1;
    end
    s_d.gear_acc = gsum[18] ? 18'h3FFFF : gsum[17:0];

    // Register writes
    if (i_wr) begin
      if (a < `SMDS_REG_ACCEL_BASE) begin
        s_d.spd[a[2:0]] = i_wdata;
      end else if (a < `SMDS_REG_DECEL_BASE) begin
        s_d.acc[a[2:0]] = i_wdata;
      end else if (a < `SMDS_REG_TORQUE_BASE) begin
        s_d.dec[a[2:0]] = i_wdata;
      end else if (a < `SMDS_REG_SYS_PEND) begin
        s_d.trq[a[2:0]] = i_wdata;
      end else begin
        case (a)
          `SMDS_REG_SYS_PEND: begin
            s_d.sys_pend = i_wdata[2:0];
          end
          `SMDS_REG_APP_CTRL: begin
            s_d.app_ctrl = i_wdata[3:0];
          end
          `SMDS_REG_ZERO_BAND: begin
            s_d.zero_band = i_wdata;
          end
          `SMDS_REG_ATTAIN_BAND: begin
            s_d.attain_band = i_wdata;
          end
          `SMDS_REG_MOVE_MIN: begin
            s_d.move_min = i_wdata;
          end
          `SMDS_REG_GAIN: begin
            s_d.gain = i_wdata;
          end
          `SMDS_REG_CLAMP: begin
            s_d.clamp = i_wdata;
          end
          `SMDS_REG_OFFSET: begin
            // Manual offset only while automatic capture is off
            if (!s_q.app_ctrl[`SMDS_APP_AUTO_OFS]) begin
              s_d.offset = i_wdata;
            end
          end
          `SMDS_REG_GEAR_A: begin
            s_d.gear_a = i_wdata;
          end
          `SMDS_REG_GEAR_B: begin
            s_d.gear_b = i_wdata;
          end
          `SMDS_REG_AUTO_OFS: begin
            // Capture present input as offset; user applies zero volts first
            if (s_q.app_ctrl[`SMDS_APP_AUTO_OFS]) begin
              s_d.offset = i_analog_mv;
            end
          end
          default: begin
          end
        endcase
      end
    end

    // Register reads; data valid in the following cycle only
    s_d.rdata = 16'h0000;
    if (i_rd) begin
      if (a < `SMDS_REG_ACCEL_BASE) begin
        s_d.rdata = s_q.spd[a[2:0]];
      end else if (a < `SMDS_REG_DECEL_BASE) begin
        s_d.rdata = s_q.acc[a[2:0]];
      end else if (a < `SMDS_REG_TORQUE_BASE) begin
        s_d.rdata = s_q.dec[a[2:0]];
      end else if (a < `SMDS_REG_SYS_PEND) begin
        s_d.rdata = s_q.trq[a[2:0]];
      end else begin
        case (a)
          `SMDS_REG_SYS_PEND: s_d.rdata = {13'h0000, s_q.sys_pend};
          `SMDS_REG_SYS_ACTIVE: s_d.rdata = {13'h0000, s_q.sys_act};
          `SMDS_REG_APP_CTRL: s_d.rdata = {12'h000, s_q.app_ctrl};
          `SMDS_REG_ZERO_BAND: s_d.rdata = s_q.zero_band;
          `SMDS_REG_ATTAIN_BAND: s_d.rdata = s_q.attain_band;
          `SMDS_REG_MOVE_MIN: s_d.rdata = s_q.move_min;
          `SMDS_REG_GAIN: s_d.rdata = s_q.gain;
          `SMDS_REG_CLAMP: s_d.rdata = s_q.clamp;
          `SMDS_REG_OFFSET: s_d.rdata = s_q.offset;
          `SMDS_REG_GEAR_A: s_d.rdata = s_q.gear_a;
          `SMDS_REG_GEAR_B: s_d.rdata = s_q.gear_b;
          `SMDS_REG_STATUS: begin
            s_d.rdata = {5'h00, s_q.sel_idx, s_q.run, s_q.excite, s_q.brake_rel,
                         s_q.zero_out, s_q.attain_out, s_q.move_out, s_q.enc_out};
          end
          `SMDS_REG_CMD_SPEED: s_d.rdata = s_q.cmd_speed;
          default: s_d.rdata = 16'h0000;
        endcase
      end
    end

    // Power cycle: everything restarts, pending system settings become active
    if (i_rst) begin
      s_d = smds_reset_state();
      s_d.sys_pend = s_q.sys_pend;
      s_d.sys_act = s_q.sys_pend;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_por) begin
      s_q <= smds_reset_state();
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign o_rdata = s_q.rdata;
  assign o_speed_cmd = s_q.cmd_speed;
  assign o_accel_time = s_q.cmd_acc;
  assign o_decel_time = s_q.cmd_dec;
  assign o_torque_limit = s_q.cmd_trq;
  assign o_entry_index = s_q.sel_idx;
  assign o_run_cw = (s_q.run == SMDS_CW);
  assign o_run_ccw = (s_q.run == SMDS_CCW);
  assign o_excite = s_q.excite;
  assign o_brake_release = s_q.brake_rel;
  assign o_zero_speed_output = s_q.zero_out;
  assign o_speed_attained_output = s_q.attain_out;
  assign o_motion_output = s_q.move_out;
  assign o_alarm_code = s_q.alarm_out;
  assign o_encoder_pulse_out = s_q.enc_out;

endmodule

`default_nettype wire

// file: dv/smds_ctrl_model.sv
// Purpose: Motion controller that drives select and direction levels
// Assumes: Bench hands it the wanted levels
// Notes:   Levels change only just after an edge and stand until told otherwise
`timescale 1ns/1ns
`default_nettype none
module smds_ctrl_model (
  input wire logic i_clock,
  input wire logic [2:0] i_sel,
  input wire logic [1:0] i_dir,
  output logic [2:0] o_sel = 3'h0,
  output logic o_cw = 1'b0,
  output logic o_ccw = 1'b0
);
  // Select is a binary index, bit 2 most significant; direction held while asked
  always @(posedge i_clock) begin
    o_sel <= i_sel;
    o_cw <= i_dir[0];
    o_ccw <= i_dir[1];
  end
endmodule
`default_nettype wire

// file: dv/smds_selector_chk.sv
// Purpose: Port assertions for the speed mode data selector
// Assumes: Bound onto smds_selector, one clock domain
// Notes:   Select and direction pin to output path is three edges, so their history is taken three deep
`timescale 1ns/1ns
`default_nettype none
module smds_chk (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_por,
  input wire logic i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic i_entry_select_bit0,
  input wire logic i_entry_select_bit1,
  input wire logic i_entry_select_bit2,
  input wire logic i_run_clockwise_input,
  input wire logic i_run_counterclockwise_input,
  input wire logic [3:0] i_alarm_code,
  input wire logic [2:0] o_entry_index,
  input wire logic o_run_cw,
  input wire logic o_run_ccw,
  input wire logic o_excite,
  input wire logic o_brake_release,
  input wire logic o_speed_attained_output,
  input wire logic o_motion_output,
  input wire logic [3:0] o_alarm_code
);
  logic [2:0] up_q;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst || i_por);
  // Edges since reset, so that history never reaches into reset
  always_ff @(posedge i_clock) begin
    if (i_rst || i_por) up_q <= 3'h0;
    else if (up_q != 3'h4) up_q <= up_q + 3'h1;
  end
  drive_pair_a:
    assert property (o_excite == o_brake_release) else $error("excite and brake release differ");
  run_excl_a:
    assert property (!(o_run_cw && o_run_ccw)) else $error("both run outputs high");
  run_cause_a:
    assert property (up_q == 3'h4 && (o_run_cw || o_run_ccw) |->
      $past(i_run_clockwise_input, 3) ^ $past(i_run_counterclockwise_input, 3)) else $error("run without one direction");
  both_stop_a:
    assert property (up_q == 3'h4 && $past(i_run_clockwise_input, 3) && $past(i_run_counterclockwise_input, 3)
      |-> !o_run_cw && !o_run_ccw) else $error("run with both directions");
  index_follow_a:
    assert property (up_q == 3'h4 |-> o_entry_index == {$past(i_entry_select_bit2, 3),
      $past(i_entry_select_bit1, 3), $past(i_entry_select_bit0, 3)}) else $error("entry index wrong");
  motion_run_a:
    assert property (o_run_cw || o_run_ccw |=> o_motion_output) else $error("motion low while running");
  alarm_gate_a:
    assert property (o_alarm_code != 4'h0 |-> o_alarm_code == $past(i_alarm_code)) else $error("alarm code wrong");
  rdata_quiet_a:
    assert property (o_rdata != 16'h0000 |-> $past(i_rd)) else $error("read data without read");
  attain_run_a:
    assert property (o_speed_attained_output |-> $past(o_run_cw || o_run_ccw)) else $error("attained while stopped");
endmodule
bind smds_selector smds_chk i_smds_chk (.i_clock(i_clock), .i_rst(i_rst), .i_por(i_por), .i_rd(i_rd),
  .o_rdata(o_rdata), .i_entry_select_bit0(i_entry_select_bit0), .i_entry_select_bit1(i_entry_select_bit1),
  .i_entry_select_bit2(i_entry_select_bit2), .i_run_clockwise_input(i_run_clockwise_input),
  .i_run_counterclockwise_input(i_run_counterclockwise_input), .i_alarm_code(i_alarm_code),
  .o_entry_index(o_entry_index), .o_run_cw(o_run_cw), .o_run_ccw(o_run_ccw), .o_excite(o_excite),
  .o_brake_release(o_brake_release), .o_speed_attained_output(o_speed_attained_output),
  .o_motion_output(o_motion_output), .o_alarm_code(o_alarm_code));
`default_nettype wire

// file: dv/tb_top.sv
// Purpose: Self-checking bench for the speed mode data selector
// Assumes: 10 MHz clock, millisecond tick shortened to ten cycles
// Notes:   Random data from an LFSR with a fixed start value
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic i_por = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic [15:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_servo_on = 1'b0;
  logic i_brake = 1'b1;
  logic i_encoder_pulse = 1'b0;
  logic [3:0] i_alarm_code = 4'h0;
  logic [15:0] i_internal_speed_pot = 16'h0000;
  logic [15:0] i_internal_ramp_pot = 16'h0000;
  logic [15:0] i_analog_mv = 16'h0000;
  logic [15:0] i_motor_speed = 16'h0000;
  logic [15:0] o_rdata, o_speed_cmd, o_accel_time, o_decel_time, o_torque_limit;
  logic [3:0] o_alarm_code;
  logic [2:0] o_entry_index, m_sel;
  logic [2:0] sel_cmd = 3'h0;
  logic [1:0] dir_cmd = 2'h0;
  logic m_cw, m_ccw, o_run_cw, o_run_ccw, o_excite, o_brake_release;
  logic o_zero_speed_output, o_speed_attained_output, o_motion_output, o_encoder_pulse_out;
  logic [15:0] tab [0:31];
  logic [15:0] v;
  logic [31:0] rnd = 32'hF5DD632D;
  int failures = 0;
  int cmp_count = 0;
  int cyc = 0;
  int enc_cnt = 0;
  smds_ctrl_model i_smds_ctrl_model (.i_clock(i_clock), .i_sel(sel_cmd), .i_dir(dir_cmd), .o_sel(m_sel),
    .o_cw(m_cw), .o_ccw(m_ccw));
  smds_selector #(.P_CYC_PER_MS(10)) i_smds_selector (.i_clock(i_clock), .i_rst(i_rst), .i_por(i_por),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_entry_select_bit0(m_sel[0]), .i_entry_select_bit1(m_sel[1]), .i_entry_select_bit2(m_sel[2]),
    .i_run_clockwise_input(m_cw), .i_run_counterclockwise_input(m_ccw), .i_servo_on(i_servo_on),
    .i_brake(i_brake), .i_internal_speed_pot(i_internal_speed_pot), .i_internal_ramp_pot(i_internal_ramp_pot),
    .i_analog_mv(i_analog_mv), .i_motor_speed(i_motor_speed), .i_alarm_code(i_alarm_code),
    .i_encoder_pulse(i_encoder_pulse), .o_speed_cmd(o_speed_cmd), .o_accel_time(o_accel_time),
    .o_decel_time(o_decel_time), .o_torque_limit(o_torque_limit), .o_entry_index(o_entry_index),
    .o_run_cw(o_run_cw), .o_run_ccw(o_run_ccw), .o_excite(o_excite), .o_brake_release(o_brake_release),
    .o_zero_speed_output(o_zero_speed_output), .o_speed_attained_output(o_speed_attained_output),
    .o_motion_output(o_motion_output), .o_alarm_code(o_alarm_code), .o_encoder_pulse_out(o_encoder_pulse_out));
  // ----------------------------------------------------------------
  // Clock, watchdog and helpers
  // ----------------------------------------------------------------
  always #50 i_clock = ~i_clock;
  // Watchdog far above the few hundred cycles the run needs
  always @(posedge i_clock) begin
    cyc++;
    if (o_encoder_pulse_out === 1'b1) enc_cnt++;
    if (cyc == 20000) begin
      failures++;
      conclude();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Offset removed first, negative clipped, gain per volt, then clamp
  function automatic logic [15:0] ana(input logic [15:0] mv, input logic [15:0] ofs, input logic [15:0] g,
    input logic [15:0] cl);
    longint s;
    s = longint'($signed(mv)) - longint'($signed(ofs));
    s = (s < 0) ? 0 : (s * g) / 1000;
    if (s > 65535) s = 65535;
    return (s < cl) ? 16'h0000 : s[15:0];
  endfunction
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clock);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask
  task automatic rchk(input string what, input logic [7:0] a, input logic [15:0] exp);
    @(posedge i_clock);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 chk(what, exp, o_rdata);
  endtask
  task automatic pwr();
    @(posedge i_clock);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clock);
    i_rst <= 1'b0;
  endtask
  task automatic load();
    for (int k = 0; k < 32; k++) begin
      rnd = lfsr(rnd);
      tab[k] = rnd[15:0];
      wr(k[7:0], tab[k]);
    end
  endtask
  // Five edges cover the controller flop plus the three-edge select path
  task automatic go(input logic [2:0] s, input logic [1:0] d);
    @(posedge i_clock);
    sel_cmd <= s;
    dir_cmd <= d;
    repeat (5) @(posedge i_clock);
    #1;
  endtask
  task automatic sel_chk(input logic [2:0] n, input logic an);
    logic [15:0] es, ea, ed;
    go(n, 2'h0);
    es = tab[n];
    ea = tab[8 + n];
    ed = tab[16 + n];
    if (an && n < 3'h2) begin
      es = (n == 3'h0) ? i_internal_speed_pot : ana(i_analog_mv, 16'h00C8, 16'h0226, 16'h0064);
      ea = i_internal_ramp_pot;
      ed = i_internal_ramp_pot;
    end
    chk("index", 16'(n), 16'(o_entry_index));
    chk("speed", es, o_speed_cmd);
    chk("accel", ea, o_accel_time);
    chk("decel", ed, o_decel_time);
    chk("torque", tab[24 + n], o_torque_limit);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge i_clock);
    i_por <= 1'b0;
    i_rst <= 1'b0;
    rchk("gain", 8'h26, 16'h0226);
    rchk("sys active", 8'h21, 16'h0001);
    rchk("gear a", 8'h29, 16'h0001);
    rchk("unmapped", 8'h3F, 16'h0000);
    $display("test reset values done");
    load();
    wr(8'h27, 16'h0064);
    wr(8'h28, 16'h00C8);
    for (int j = 0; j < 4; j++) begin
      rnd = lfsr(rnd);
      i_internal_speed_pot <= rnd[15:0];
      i_internal_ramp_pot <= rnd[31:16];
      i_analog_mv <= (j == 0) ? 16'h0BB8 : (j == 1) ? 16'h0140 : (j == 2) ? 16'hFC18 : {4'h0, rnd[11:0]};
      sel_chk(3'h1, 1'b1);
    end
    for (int j = 0; j < 8; j++) sel_chk(j[2:0], 1'b1);
    $display("test analog entries done");
    wr(8'h20, 16'h0000);
    rchk("active before cycle", 8'h21, 16'h0001);
    pwr();
    rchk("active after cycle", 8'h21, 16'h0000);
    load();
    for (int j = 7; j >= 0; j--) sel_chk(j[2:0], 1'b0);
    $display("test digital entries done");
    wr(8'h25, 16'h0003);
    wr(8'h24, 16'hFFFF);
    go(3'h5, 2'h1);
    repeat (8) begin
      @(posedge i_clock);
      #1 chk("run held", 16'h0001, 16'({o_run_cw, o_excite, o_speed_attained_output} == 3'h7));
    end
    go(3'h5, 2'h0);
    chk("stopped", 16'h0001, 16'({o_run_cw, o_excite, o_motion_output}));
    repeat (5) @(posedge i_clock);
    #1 chk("motion min", 16'h0001, 16'(o_motion_output));
    repeat (30) @(posedge i_clock);
    #1 chk("motion end", 16'h0000, 16'(o_motion_output));
    go(3'h2, 2'h3);
    chk("both dirs", 16'h0000, 16'({o_run_cw, o_run_ccw}));
    go(3'h2, 2'h2);
    chk("ccw", 16'h0001, 16'({o_run_cw, o_run_ccw}));
    go(3'h2, 2'h0);
    $display("test run done");
    i_alarm_code <= 4'hA;
    wr(8'h22, 16'h0000);
    #1 chk("alarm off", 16'h0000, 16'(o_alarm_code));
    wr(8'h22, 16'h0004);
    wr(8'h23, 16'h0010);
    #1 chk("alarm on", 16'h000A, 16'(o_alarm_code));
    i_motor_speed <= 16'h0008;
    repeat (3) @(posedge i_clock);
    #1 chk("zero in band", 16'h0001, 16'(o_zero_speed_output));
    i_motor_speed <= 16'hFFE0;
    repeat (3) @(posedge i_clock);
    #1 chk("zero out band", 16'h0000, 16'(o_zero_speed_output));
    wr(8'h22, 16'h0008);
    i_analog_mv <= 16'h0064;
    wr(8'h2D, 16'h0000);
    wr(8'h28, 16'h0123);
    rchk("auto offset", 8'h28, 16'h0064);
    wr(8'h29, 16'h0002);
    enc_cnt = 0;
    repeat (10) begin
      @(posedge i_clock);
      i_encoder_pulse <= 1'b1;
      @(posedge i_clock);
      i_encoder_pulse <= 1'b0;
    end
    repeat (4) @(posedge i_clock);
    chk("gear pulses", 16'h0005, 16'(enc_cnt));
    $display("test settings done");
    wr(8'h20, 16'h0002);
    pwr();
    i_servo_on <= 1'b1;
    go(3'h0, 2'h0);
    chk("lock excite", 16'h0003, 16'({o_excite, o_brake_release}));
    wr(8'h22, 16'h0001);
    go(3'h0, 2'h0);
    chk("son inverted", 16'h0000, 16'(o_excite));
    wr(8'h22, 16'h0002);
    go(3'h0, 2'h1);
    chk("brake inverted", 16'h0000, 16'(o_run_cw));
    go(3'h0, 2'h0);
    $display("test servo lock done");
    conclude();
  end
endmodule
`default_nettype wire
